// ### pmoe_pin_ctrl.sv
// The AHB-Lite interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "pmoe_params.svh"
// Functional notes
// - Serial mode: inputs 0,1,4 are data, clock, ref select; status unlock and ref loss
// - Mode pin low gives scan: inputs carry scan signals, status0 is scan data out
// - All-PLL mode locks to primary; switchover follows primary select bit
// - At power-up act as all-PLL mode and latch inputs 0..3
// - Input 4 not latched and reads low during programming; config then holds
// - Outside programming the select inputs set the configuration live
// - Disabled select inputs read as low; power-up latch still happens
// - Inputs 0..3 serve programming even disabled; disabled input 4 is inert
// - Polarity bit: 0 active high, 1 active low enable pin
// - Function bit 1 makes pin a global shutdown overriding power-down bits
// - With function bit 0, asserted enable pin turns off masked banks only
// - Off bank: level 0x hi-Z, 10 low, 11 high, inverted parks opposite
// - Shutdown: outputs hi-Z, oscillator off, mode pin mid, programming refused
// - Shutdown keeps select inputs working and PLLs running
// - Mode bit 0: inputs 0,1 PLL0; 2 PLL1; 3,4 PLL2; divider bit per config
// - Mode bit 1: inputs 0..2 pick eight PLL0 configs, 4..7 borrowed
// - Mid mode pin: mode bit 1 PLL0-only, 0 all-PLL
module pmoe_pin_ctrl
#(
    parameter int LATCH_WAIT = `PMOE_LATCH_WAIT
)
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        clk_en,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic      [31:0] hrdata,
    input  wire logic        select_in0,
    input  wire logic        select_in1,
    input  wire logic        select_in2,
    input  wire logic        select_in3,
    input  wire logic        select_in4,
    input  wire logic        mode_pin_high,
    input  wire logic        mode_pin_low,
    input  wire logic        enable_pin,
    input  wire logic        pll_unlock,
    input  wire logic        ref_missing_flag,
    input  wire logic        scan_tdo,
    output logic             status_out0,
    output logic             status_out1,
    output logic             serial_data_pin,
    output logic             serial_clk,
    output logic             scan_tdi,
    output logic             scan_tck,
    output logic             scan_tms,
    output logic             scan_trst_n,
    output logic             prog_enable,
    output logic             ref_sel_secondary,
    output logic             osc_power_down,
    output logic             shutdown_active,
    output logic      [2:0]  pll_power_down,
    output logic      [5:0]  bank_off,
    output logic      [5:0]  bank_hiz,
    output logic      [5:0]  bank_park_level,
    output logic      [1:0]  pll0_cfg,
    output logic      [1:0]  pll0_src,
    output logic      [1:0]  pll1_cfg,
    output logic      [1:0]  pll2_cfg,
    output logic      [2:0]  pll_div
);
    import pmoe_pkg::*;

    localparam pmoe_core_type CORE_RST = '{
        mode:     PMOE_MODE_ALL,
        ser_data: 1'b1,
        ser_clk:  1'b1,
        default:  '0
    };

    if (LATCH_WAIT < 1 || LATCH_WAIT > 7)
    begin : g_chk
        $error("pmoe_pin_ctrl LATCH_WAIT must be 1 to 7");
    end

    pmoe_core_type r;
    pmoe_core_type next_r;

    logic [7:0]  pins_q;
    logic [4:0]  sel_pin;
    logic        mode_hi;
    logic        mode_lo;
    logic [6:0]  ctrl_q;
    logic [4:0]  select_input_enable;
    logic [17:0] bank_q;
    logic [11:0] post_divider_select;
    logic [5:0]  inv_q;
    logic [31:0] status_word;

    logic        freq_select_mode_bit;
    logic        enable_pin_polarity;
    logic        enable_pin_function;
    logic        primary_ref_select;
    logic [2:0]  pll_power_down_bits;
    logic [5:0]  bank_mask_bits;
    logic [5:0]  bank_power_down_bits;
    logic [1:0]  disabled_output_level;

    logic        pin_act;
    logic        shut;
    logic        prog_now;
    logic [5:0]  bank_dis;
    logic [5:0]  bank_z;
    logic [5:0]  bank_lv;

    // Pins come from the board, so they cross into hclk here
    pmoe_sync #(.W(8)) u_sync
    (
        .hclk    (hclk),
        .hresetn (hresetn),
        .clk_en  (clk_en),
        .d       ({enable_pin, mode_pin_low, mode_pin_high, select_in4,
                   select_in3, select_in2, select_in1, select_in0}),
        .q       (pins_q)
    );

    pmoe_ahb u_ahb
    (
        .hclk        (hclk),
        .hresetn     (hresetn),
        .clk_en      (clk_en),
        .hsel        (hsel),
        .haddr       (haddr),
        .htrans      (htrans),
        .hwrite      (hwrite),
        .hsize       (hsize),
        .hwdata      (hwdata),
        .hready      (hready),
        .status_word (status_word),
        .hreadyout   (hreadyout),
        .hresp       (hresp),
        .hrdata      (hrdata),
        .ctrl_q      (ctrl_q),
        .selen_q     (select_input_enable),
        .bank_q      (bank_q),
        .div_q       (post_divider_select),
        .inv_q       (inv_q)
    );

    assign sel_pin = pins_q[4:0];
    assign mode_hi = pins_q[5];
    assign mode_lo = pins_q[6];

    assign freq_select_mode_bit  = ctrl_q[`PMOE_CTRL_FREQ];
    assign enable_pin_polarity   = ctrl_q[`PMOE_CTRL_POL];
    assign enable_pin_function   = ctrl_q[`PMOE_CTRL_FUNC];
    assign primary_ref_select    = ctrl_q[`PMOE_CTRL_PRIM];
    assign pll_power_down_bits   = ctrl_q[`PMOE_CTRL_PLLPD +: 3];
    assign bank_mask_bits        = bank_q[`PMOE_BANK_MASK +: 6];
    assign bank_power_down_bits  = bank_q[`PMOE_BANK_PD +: 6];
    assign disabled_output_level = bank_q[`PMOE_BANK_LEVEL +: 2];

    assign status_word = {20'h0, r.ref_sel, r.cfg, r.ready, r.shut, r.mode};

    assign pin_act  = pins_q[7] ^ enable_pin_polarity;
    assign shut     = pin_act & enable_pin_function;
    assign prog_now = (r.mode == PMOE_MODE_SERIAL) || (r.mode == PMOE_MODE_SCAN);

    // Power-down bits still turn a bank off when the pin is a shutdown
    for (genvar i = 0; i < `PMOE_NBANK; i++)
    begin : g_bank
        assign bank_dis[i] = shut | bank_power_down_bits[i]
                           | (!enable_pin_function & pin_act & bank_mask_bits[i]);
        assign bank_z[i]   = shut | (bank_dis[i] & !disabled_output_level[1]);
        assign bank_lv[i]  = disabled_output_level[0] ^ inv_q[i];
    end

    always_comb
    begin
        next_r = r;
        if (clk_en)
        begin
            if (!r.ready)
            begin
                // Wait for the pin filters to settle before latching
                next_r.mode     = PMOE_MODE_ALL;
                next_r.wait_cnt = r.wait_cnt + 3'h1;
                if (r.wait_cnt == 3'(LATCH_WAIT - 1))
                begin
                    next_r.ready = 1'b1;
                    next_r.cfg   = {1'b0, sel_pin[3:0]};
                end
            end
            else
            begin
                // Both comparators high is not a real level; treat as mid
                if (shut || mode_hi == mode_lo)
                    next_r.mode = freq_select_mode_bit ? PMOE_MODE_PLL0 : PMOE_MODE_ALL;
                else if (mode_hi)
                    next_r.mode = PMOE_MODE_SERIAL;
                else
                    next_r.mode = PMOE_MODE_SCAN;
                if (prog_now)
                    next_r.cfg = {1'b0, r.cfg[3:0]};
                else
                    next_r.cfg = sel_pin & select_input_enable;
            end

            if (r.mode == PMOE_MODE_PLL0)
            begin
                next_r.pll0_src = r.cfg[2] ? (r.cfg[1] ? 2'd2 : 2'd1) : 2'd0;
                next_r.pll0_cfg = r.cfg[2] ? {1'b1, r.cfg[0]} : r.cfg[1:0];
                next_r.pll1_cfg = 2'd0;
                next_r.pll2_cfg = 2'd0;
            end
            else
            begin
                next_r.pll0_src = 2'd0;
                next_r.pll0_cfg = r.cfg[1:0];
                next_r.pll1_cfg = {1'b0, r.cfg[2]};
                next_r.pll2_cfg = r.cfg[4:3];
            end
            next_r.div[0] = post_divider_select[{next_r.pll0_src, next_r.pll0_cfg}];
            next_r.div[1] = post_divider_select[{2'd1, next_r.pll1_cfg}];
            next_r.div[2] = post_divider_select[{2'd2, next_r.pll2_cfg}];

            // All-PLL mode borrows input 4 for configuration
            if (r.mode == PMOE_MODE_ALL)
                next_r.ref_sel = primary_ref_select;
            else
                next_r.ref_sel = select_input_enable[4] & sel_pin[4];

            // Programming pins ignore the enables
            next_r.ser_data = (r.mode == PMOE_MODE_SERIAL) ? sel_pin[0] : 1'b1;
            next_r.ser_clk  = (r.mode == PMOE_MODE_SERIAL) ? sel_pin[1] : 1'b1;
            next_r.tdi      = (r.mode == PMOE_MODE_SCAN) & sel_pin[0];
            next_r.tck      = (r.mode == PMOE_MODE_SCAN) & sel_pin[1];
            next_r.tms      = (r.mode == PMOE_MODE_SCAN) & sel_pin[2];
            next_r.trst_n   = (r.mode == PMOE_MODE_SCAN) & sel_pin[3];
            next_r.prog     = prog_now & !shut;
            next_r.status0  = (r.mode == PMOE_MODE_SCAN) ? scan_tdo : pll_unlock;
            next_r.status1  = ref_missing_flag;

            next_r.shut   = shut;
            next_r.osc_pd = shut;
            next_r.pll_pd = shut ? 3'h0 : pll_power_down_bits;
            next_r.off    = bank_dis;
            next_r.hiz    = bank_z;
            next_r.park   = bank_lv;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            r <= CORE_RST;
        else
            r <= next_r;
    end

    assign status_out0       = r.status0;
    assign status_out1       = r.status1;
    assign serial_data_pin   = r.ser_data;
    assign serial_clk        = r.ser_clk;
    assign scan_tdi          = r.tdi;
    assign scan_tck          = r.tck;
    assign scan_tms          = r.tms;
    assign scan_trst_n       = r.trst_n;
    assign prog_enable       = r.prog;
    assign ref_sel_secondary = r.ref_sel;
    assign osc_power_down    = r.osc_pd;
    assign shutdown_active   = r.shut;
    assign pll_power_down    = r.pll_pd;
    assign bank_off          = r.off;
    assign bank_hiz          = r.hiz;
    assign bank_park_level   = r.park;
    assign pll0_cfg          = r.pll0_cfg;
    assign pll0_src          = r.pll0_src;
    assign pll1_cfg          = r.pll1_cfg;
    assign pll2_cfg          = r.pll2_cfg;
    assign pll_div           = r.div;

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    property p_scan_status;
        clk_en && r.mode == PMOE_MODE_SCAN |=> status_out0 == $past(scan_tdo);
    endproperty
    a_scan_status: assert property (p_scan_status)
        else $error("scan data out not on status 0");

    property p_serial_map;
        clk_en && r.mode == PMOE_MODE_SERIAL
            |=> serial_data_pin == $past(pins_q[0]) && serial_clk == $past(pins_q[1]);
    endproperty
    a_serial_map: assert property (p_serial_map)
        else $error("serial pins not routed from inputs 0 and 1");

    property p_prog_hold;
        clk_en && r.ready && prog_now |=> !r.cfg[4] && r.cfg[3:0] == $past(r.cfg[3:0]);
    endproperty
    a_prog_hold: assert property (p_prog_hold)
        else $error("configuration moved during programming");

    property p_live_cfg;
        clk_en && r.ready && !prog_now |=> r.cfg == $past(sel_pin & select_input_enable);
    endproperty
    a_live_cfg: assert property (p_live_cfg)
        else $error("configuration not following enabled inputs");

    property p_powerup;
        $rose(r.ready) |-> r.cfg == {1'b0, $past(sel_pin[3:0])} && r.mode == PMOE_MODE_ALL;
    endproperty
    a_powerup: assert property (p_powerup)
        else $error("power-up latch wrong");

    property p_shutdown;
        clk_en && shut |=> bank_hiz == 6'h3F && pll_power_down == 3'h0 && !prog_enable
            && osc_power_down;
    endproperty
    a_shutdown: assert property (p_shutdown)
        else $error("shutdown did not park outputs");

    property p_mask;
        clk_en && !shut && !bank_mask_bits[0] && !bank_power_down_bits[0] |=> !bank_off[0];
    endproperty
    a_mask: assert property (p_mask)
        else $error("unmasked bank turned off");

    property p_park;
        clk_en && bank_dis[0] && !shut && disabled_output_level == 2'b11
            |=> !bank_hiz[0] && bank_park_level[0] == !$past(inv_q[0]);
    endproperty
    a_park: assert property (p_park)
        else $error("off bank parked at wrong level");

    property p_borrow;
        clk_en && r.mode == PMOE_MODE_PLL0 && r.cfg[2:1] == 2'b11
            |=> pll0_src == 2'd2 && pll0_cfg[1];
    endproperty
    a_borrow: assert property (p_borrow)
        else $error("configs 6 and 7 not taken from PLL2");

    property p_all_pll;
        clk_en && r.mode == PMOE_MODE_ALL
            |=> pll2_cfg == $past(r.cfg[4:3]) && ref_sel_secondary == $past(primary_ref_select);
    endproperty
    a_all_pll: assert property (p_all_pll)
        else $error("all-PLL mapping or reference select wrong");

    property p_mode_high;
        clk_en && r.ready && mode_hi && !mode_lo && !shut |=> r.mode == PMOE_MODE_SERIAL;
    endproperty
    a_mode_high: assert property (p_mode_high)
        else $error("high mode pin did not give serial mode");

    c_serial: cover property (r.mode == PMOE_MODE_SERIAL);
    c_scan: cover property (r.mode == PMOE_MODE_SCAN);
    c_pll0: cover property (r.mode == PMOE_MODE_PLL0 && r.cfg[2]);
    c_shut: cover property (shutdown_active && bank_hiz == 6'h3F);

endmodule : pmoe_pin_ctrl

// ### pmoe_params.svh
`ifndef PMOE_PARAMS_SVH
`define PMOE_PARAMS_SVH

// Register byte offsets
`define PMOE_ADDR_CTRL   8'h00
`define PMOE_ADDR_SELEN  8'h04
`define PMOE_ADDR_BANK   8'h08
`define PMOE_ADDR_DIV    8'h0C
`define PMOE_ADDR_INV    8'h10
`define PMOE_ADDR_STATUS 8'h14

// Control register fields
`define PMOE_CTRL_FREQ   0
`define PMOE_CTRL_POL    1
`define PMOE_CTRL_FUNC   2
`define PMOE_CTRL_PRIM   3
`define PMOE_CTRL_PLLPD  4

// Bank register fields
`define PMOE_BANK_MASK   0
`define PMOE_BANK_PD     8
`define PMOE_BANK_LEVEL  16

// Reset values
`define PMOE_CTRL_RST    7'h00
`define PMOE_SELEN_RST   5'h1F
`define PMOE_BANK_RST    18'h00000
`define PMOE_DIV_RST     12'h000
`define PMOE_INV_RST     6'h00

// Output banks and power-up settle time in cycles
`define PMOE_NBANK       6
`define PMOE_LATCH_WAIT  4

`endif

// ### pmoe_pkg.sv
package pmoe_pkg;

    typedef enum logic [3:0]
    {
        PMOE_MODE_PLL0   = 4'h1,
        PMOE_MODE_ALL    = 4'h2,
        PMOE_MODE_SERIAL = 4'h4,
        PMOE_MODE_SCAN   = 4'h8
    } pmoe_mode_type;

    typedef struct packed
    {
        logic        ready;
        logic [2:0]  wait_cnt;
        logic [3:0]  mode;
        logic [4:0]  cfg;
        logic        status0;
        logic        status1;
        logic        ser_data;
        logic        ser_clk;
        logic        tdi;
        logic        tck;
        logic        tms;
        logic        trst_n;
        logic        prog;
        logic        ref_sel;
        logic        osc_pd;
        logic        shut;
        logic [2:0]  pll_pd;
        logic [5:0]  off;
        logic [5:0]  hiz;
        logic [5:0]  park;
        logic [1:0]  pll0_cfg;
        logic [1:0]  pll0_src;
        logic [1:0]  pll1_cfg;
        logic [1:0]  pll2_cfg;
        logic [2:0]  div;
    } pmoe_core_type;

    typedef struct packed
    {
        logic        wr_pend;
        logic [7:0]  wr_addr;
        logic [31:0] rdata;
        logic        ready_out;
        logic        resp;
        logic [6:0]  ctrl;
        logic [4:0]  selen;
        logic [17:0] bank;
        logic [11:0] div;
        logic [5:0]  inv;
    } pmoe_ahb_type;

endpackage : pmoe_pkg

// ### pmoe_sync.sv
`timescale 1ns/1ps
module pmoe_sync
#(
    parameter int W = 8
)
(
    input  wire logic         hclk,
    input  wire logic         hresetn,
    input  wire logic         clk_en,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    import pmoe_pkg::*;

    typedef struct packed
    {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } pmoe_sync_type;

    pmoe_sync_type r;
    pmoe_sync_type next_r;

    if (W < 1)
    begin : g_chk
        $error("pmoe_sync width must be at least 1");
    end

    // A bit moves only once stages two and three agree
    always_comb
    begin
        next_r = r;
        if (clk_en)
        begin
            next_r.s1 = d;
            next_r.s2 = r.s1;
            next_r.s3 = r.s2;
            for (int i = 0; i < W; i++)
            begin
                if (r.s2[i] == r.s3[i])
                    next_r.q[i] = r.s3[i];
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            r <= '0;
        else
            r <= next_r;
    end

    assign q = r.q;

endmodule : pmoe_sync

// ### pmoe_ahb.sv
`timescale 1ns/1ps
`include "pmoe_params.svh"
module pmoe_ahb
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        clk_en,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    input  wire logic [31:0] status_word,
    output logic             hreadyout,
    output logic             hresp,
    output logic      [31:0] hrdata,
    output logic      [6:0]  ctrl_q,
    output logic      [4:0]  selen_q,
    output logic      [17:0] bank_q,
    output logic      [11:0] div_q,
    output logic      [5:0]  inv_q
);
    import pmoe_pkg::*;

    localparam pmoe_ahb_type AHB_RST = '{
        ready_out: 1'b1,
        ctrl:      `PMOE_CTRL_RST,
        selen:     `PMOE_SELEN_RST,
        bank:      `PMOE_BANK_RST,
        div:       `PMOE_DIV_RST,
        inv:       `PMOE_INV_RST,
        default:   '0
    };

    pmoe_ahb_type r;
    pmoe_ahb_type next_r;
    logic [31:0]  rd;
    logic         start;
    logic         mapped;

    always_comb
    begin
        rd = 32'h0;
        case (haddr[7:0])
            `PMOE_ADDR_CTRL:   rd = {25'h0, r.ctrl};
            `PMOE_ADDR_SELEN:  rd = {27'h0, r.selen};
            `PMOE_ADDR_BANK:   rd = {14'h0, r.bank};
            `PMOE_ADDR_DIV:    rd = {20'h0, r.div};
            `PMOE_ADDR_INV:    rd = {26'h0, r.inv};
            `PMOE_ADDR_STATUS: rd = status_word;
            default:           rd = 32'h0;
        endcase
        start  = hsel & hready & htrans[1];
        mapped = (haddr[31:8] == 24'h0) & (haddr[1:0] == 2'b00) & (hsize == 3'b010);
        next_r = r;
        if (clk_en)
        begin
            // Zero-wait slave: write lands in the data phase
            if (r.wr_pend)
            begin
                case (r.wr_addr)
                    `PMOE_ADDR_CTRL:  next_r.ctrl  = hwdata[6:0];
                    `PMOE_ADDR_SELEN: next_r.selen = hwdata[4:0];
                    `PMOE_ADDR_BANK:  next_r.bank  = hwdata[17:0];
                    `PMOE_ADDR_DIV:   next_r.div   = hwdata[11:0];
                    `PMOE_ADDR_INV:   next_r.inv   = hwdata[5:0];
                    default:          next_r.inv   = r.inv;
                endcase
            end
            next_r.wr_pend = start & hwrite & mapped;
            next_r.wr_addr = haddr[7:0];
            // Unmapped or odd-sized reads answer zero, never an error
            if (start & !hwrite)
                next_r.rdata = mapped ? rd : 32'h0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            r <= AHB_RST;
        else
            r <= next_r;
    end

    assign hreadyout = r.ready_out;
    assign hresp     = r.resp;
    assign hrdata    = r.rdata;
    assign ctrl_q    = r.ctrl;
    assign selen_q   = r.selen;
    assign bank_q    = r.bank;
    assign div_q     = r.div;
    assign inv_q     = r.inv;

endmodule : pmoe_ahb

// ### pmoe_host.sv
`timescale 1ns/1ps
module pmoe_host
(
    input  wire logic       hclk,
    input  wire logic       hresetn,
    input  wire logic [4:0] sel_cmd,
    input  wire logic [1:0] mode_cmd,
    input  wire logic       oe_cmd,
    output logic            select_in0,
    output logic            select_in1,
    output logic            select_in2,
    output logic            select_in3,
    output logic            select_in4,
    output logic            mode_pin_high,
    output logic            mode_pin_low,
    output logic            enable_pin
);
    logic [3:0] up_cnt;
    // Pins held low well past the power-up latch so config 0 is taken
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            up_cnt <= 4'h0;
            {select_in4, select_in3, select_in2, select_in1, select_in0} <= 5'h00;
            {mode_pin_high, mode_pin_low, enable_pin} <= 3'h0;
        end
        else
        begin
            up_cnt <= (up_cnt == 4'hF) ? up_cnt : up_cnt + 4'h1;
            {select_in4, select_in3, select_in2, select_in1, select_in0} <= (up_cnt == 4'hF) ? sel_cmd : 5'h00;
            mode_pin_high <= (mode_cmd == 2'h1);
            mode_pin_low  <= (mode_cmd == 2'h2);
            enable_pin    <= oe_cmd;
        end
    end
endmodule : pmoe_host

// ### tb.sv
`timescale 1ns/1ps
module tb;
    logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, clk_en, oe_cmd;
    logic [31:0] haddr, hwdata, hrdata, rdata;
    logic [1:0]  htrans, mode_cmd, pll0_cfg, pll0_src, pll1_cfg, pll2_cfg;
    logic [2:0]  hsize, pll_power_down, pll_div;
    logic [4:0]  sel_cmd;
    logic [5:0]  bank_off, bank_hiz, bank_park_level;
    logic        select_in0, select_in1, select_in2, select_in3, select_in4;
    logic        mode_pin_high, mode_pin_low, enable_pin, pll_unlock, ref_missing_flag, scan_tdo;
    logic        status_out0, status_out1, serial_data_pin, serial_clk;
    logic        scan_tdi, scan_tck, scan_tms, scan_trst_n;
    logic        prog_enable, ref_sel_secondary, osc_power_down, shutdown_active;
    int          num_errors, n_compared, seed, s, m, k, mask, inv, dv;
    assign hready = hreadyout;
    pmoe_pin_ctrl dut (.*);
    pmoe_host host (.*);
    initial
    begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    task automatic summarize;
        $display("Compared %0d, errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : summarize
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // Holds address phase until hready, then data phase until hready again
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        hwrite <= wr;
        htrans <= 2'h2;
        do
        begin
            @(posedge hclk);
            n++;
        end
        while (hreadyout !== 1'b1 && n < 50);
        htrans <= 2'h0;
        hwdata <= d;
        do
        begin
            @(posedge hclk);
            n++;
        end
        while (hreadyout !== 1'b1 && n < 100);
        rdata = hrdata;
        if (n >= 100)
        begin
            num_errors++;
            summarize;
        end
    endtask : bus
    // Pin to output takes about six cycles through the synchroniser
    task automatic settle;
        repeat (10) @(posedge hclk);
    endtask : settle
    task automatic cfg_chk(input int fb, input int v, input int prim);
        int c0, s0;
        c0 = (fb && (v & 4)) ? (2 | (v & 1)) : (v & 3);
        s0 = (fb && (v & 4)) ? ((v & 2) ? 2 : 1) : 0;
        check(pll0_cfg, c0);
        check(pll0_src, s0);
        // Divider bit index is four per PLL plus the config in use
        check(pll_div, {dv[8 + (fb ? 0 : (v >> 3) & 3)], dv[4 + (fb ? 0 : (v >> 2) & 1)], dv[4 * s0 + c0]});
        check(pll1_cfg, fb ? 0 : (v >> 2) & 1);
        check(pll2_cfg, fb ? 0 : (v >> 3) & 3);
        check(ref_sel_secondary, fb ? (v >> 4) & 1 : prim);
    endtask : cfg_chk
    initial
    begin
        seed = 32'h8E0911DB;
        {hresetn, hsel, hwrite, htrans, haddr, hwdata, oe_cmd} = '0;
        {pll_unlock, ref_missing_flag, scan_tdo, sel_cmd, mode_cmd} = '0;
        {hsize, clk_en} = 4'h5;
        num_errors = 0;
        n_compared = 0;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (20) @(posedge hclk);
        cfg_chk(0, 0, 0);
        bus(1'b0, 8'h04, 32'h0);
        check({hresp, rdata[30:0]}, 32'h1F);
        bus(1'b0, 8'h40, 32'h0);
        check(rdata, 32'h0);
        dv = $random(seed) & 32'hFFF;
        bus(1'b1, 8'h0C, dv);
        for (m = 0; m < 2; m++)
        begin
            bus(1'b1, 8'h00, m | 8);
            for (k = 0; k < 6; k++)
            begin
                s = $random(seed) & 31;
                sel_cmd <= s[4:0];
                settle;
                cfg_chk(m, s, 1);
            end
            bus(1'b0, 8'h14, 32'h0);
            check(rdata & 15, m ? 1 : 2);
        end
        bus(1'b1, 8'h00, 32'h8);
        bus(1'b1, 8'h04, 32'h0);
        sel_cmd <= 5'h1F;
        settle;
        cfg_chk(0, 0, 1);
        for (m = 1; m < 3; m++)
            for (k = 0; k < 2; k++)
            begin
                s = $random(seed);
                {pll_unlock, ref_missing_flag, scan_tdo, sel_cmd} <= s[7:0];
                mode_cmd <= m[1:0];
                settle;
                check({prog_enable, ref_sel_secondary, status_out1}, {2'b10, s[6]});
                if (m == 1)
                    check({serial_data_pin, serial_clk, status_out0, pll2_cfg[1]}, {s[0], s[1], s[7], 1'b0});
                else
                    check({scan_tdi, scan_tck, scan_tms, scan_trst_n, status_out0}, {s[0], s[1], s[2], s[3], s[5]});
            end
        bus(1'b1, 8'h04, 32'h1F);
        mode_cmd <= 2'h0;
        for (m = 0; m < 8; m++)
        begin
            mask = $random(seed) & 63;
            inv = $random(seed) & 63;
            bus(1'b1, 8'h00, (m & 1) << 1);
            bus(1'b1, 8'h08, mask | ((m >> 1) << 16));
            bus(1'b1, 8'h10, inv);
            oe_cmd <= ~m[0];
            settle;
            check(bank_off, mask);
            check(bank_hiz, (m & 4) ? 0 : mask);
            check(bank_park_level & bank_off & ~bank_hiz, (m & 4) ? (((m & 2) ? mask : 0) ^ (inv & mask)) : 0);
            oe_cmd <= m[0];
            settle;
            check(bank_off, 0);
        end
        bus(1'b1, 8'h00, 32'h74);
        // Mode pin high during shutdown must still read as frequency control
        {mode_cmd, oe_cmd, sel_cmd} <= 8'h63;
        settle;
        check({shutdown_active, osc_power_down, prog_enable, pll_power_down}, 6'h30);
        check({bank_hiz, pll0_cfg}, 8'hFF);
        bus(1'b0, 8'h14, 32'h0);
        check(rdata & 15, 2);
        oe_cmd <= 1'b0;
        settle;
        check({shutdown_active, prog_enable, pll_power_down}, 5'h0F);
        summarize;
    end
endmodule : tb
